// *** rtl/rdt_cfg.svh ***
// Register indices, field positions, reset values and timing for the
// resonant dead-time edge block. Assumes a 100 MHz controller clock.
`ifndef RDT_CFG_SVH
`define RDT_CFG_SVH

`define IDX_DRIVE_THREE_FALL 8'h4B
`define IDX_DRIVE_FOUR_RISE  8'h4D
`define IDX_DRIVE_FOUR_FALL  8'h4F
`define IDX_RECT_ONE_RISE    8'h51
`define IDX_CONTROL          8'h60
`define IDX_PERIOD           8'h61
`define IDX_STATUS           8'h62

`define ADDR_IDX_HI          9
`define ADDR_IDX_LO          2
`define ADDR_TOP_HI          11
`define ADDR_TOP_LO          10

`define CTRL_RESONANT_BIT    0
`define CODE_ADVANCE_BIT     7
`define CODE_RESET           8'h00
`define CTRL_RESET           1'b0
`define PERIOD_RESET         16'h00C8
`define PERIOD_MIN           16'h0002

`define STEP_NS              16'h0005
`define CLK_NS               16'h000A

`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// *** rtl/rdt_pkg.sv ***
// Types shared by the resonant dead-time edge block.
// Assumes rdt_cfg.svh for numeric constants.
`default_nettype none
`include "rdt_cfg.svh"

package rdt_pkg;
  typedef logic [7:0]  code_t;
  typedef logic [15:0] count_t;

  typedef struct packed {
    logic three;
    logic four;
    logic rect;
  } drive_s;

  typedef struct packed {
    code_t three_fall;
    code_t four_rise;
    code_t four_fall;
    code_t rect_rise;
  } codes_s;

  // Code steps to whole clock cycles, rounded down
  function automatic count_t to_cycles(input code_t code);
    logic [15:0] prod;
    prod = {8'h00, code} * `STEP_NS;
    return count_t'(prod / `CLK_NS);
  endfunction
endpackage

`default_nettype wire

// *** rtl/rect_edge_delay.sv ***
// Rectifier gate timing from the ac-sense pin.
// Assumes an asynchronous ac-sense level and one controller clock.
`timescale 1ns/1ps
`default_nettype none
`include "rdt_cfg.svh"

module rect_edge_delay (
  input  wire logic           i_clk,
  input  wire logic           i_rst,
  input  wire logic           i_ac_sense,
  input  wire logic           i_enable,
  input  wire rdt_pkg::count_t i_delay,
  output logic                o_gate
);
  import rdt_pkg::*;

  logic   sync1;
  logic   sync2;
  logic   sync3;
  logic   armed;
  count_t wait_cnt;
  logic   ac_rise;
  logic   ac_fall;

  // Two-stage synchroniser
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= i_ac_sense;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign ac_rise = sync2 && !sync3;
  assign ac_fall = !sync2 && sync3;

  // Delay count from ac-sense rise
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_enable || ac_fall) begin
      armed    <= 1'b0;
      wait_cnt <= '0;
    end else if (ac_rise) begin
      armed    <= 1'b1;
      wait_cnt <= i_delay;
    end else if (armed && wait_cnt != '0) begin
      wait_cnt <= wait_cnt - 16'h0001;
    end else if (armed) begin
      armed    <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !i_enable || ac_fall) begin
      o_gate <= 1'b0;
    end else if (armed && wait_cnt == '0) begin
      o_gate <= 1'b1;
    end
  end

  a_rect_fires: assert property (@(posedge i_clk) disable iff (i_rst)
    ac_rise && i_enable && i_delay == '0 |=> ##1 o_gate)
    else $error("rectifier gate not raised after zero delay");

  a_rect_early: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_gate) |-> $past(armed) && $past(wait_cnt) == '0)
    else $error("rectifier gate rose before its delay ran out");
endmodule // rect_edge_delay

`default_nettype wire

// *** rtl/resonant_dead_time_edges.sv ***
// Resonant-mode edge placement for drive outputs three and four and
// rectifier gate one, with an AXI4-Lite register slave.
// Assumes one 100 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "rdt_cfg.svh"

module resonant_dead_time_edges (
  input  wire logic           i_clk,
  input  wire logic           i_rst,
  input  wire logic [11:0]    i_awaddr,
  input  wire logic           i_awvalid,
  output logic                o_awready,
  input  wire logic [31:0]    i_wdata,
  input  wire logic [3:0]     i_wstrb,
  input  wire logic           i_wvalid,
  output logic                o_wready,
  output logic [1:0]          o_bresp,
  output logic                o_bvalid,
  input  wire logic           i_bready,
  input  wire logic [11:0]    i_araddr,
  input  wire logic           i_arvalid,
  output logic                o_arready,
  output logic [31:0]         o_rdata,
  output logic [1:0]          o_rresp,
  output logic                o_rvalid,
  input  wire logic           i_rready,
  input  wire logic           i_ac_sense_input,
  output var rdt_pkg::drive_s o_drive
);
  import rdt_pkg::*;

  codes_s       codes;
  codes_s       shadow;
  logic         resonant_en;
  count_t       period;
  count_t       period_sh;
  count_t       cnt;
  logic         run;
  logic         boundary;
  logic         aw_hold;
  logic [7:0]   aw_idx;
  logic         aw_bad;
  logic         w_hold;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic         do_write;
  logic         wr_ok;
  logic [31:0]  rd_data;
  logic         rd_ok;
  logic [7:0]   ar_idx;
  count_t       mid;
  count_t       lead3;
  count_t       lead4;
  count_t       shift4;
  count_t       rect_cyc;
  count_t       c_fall;
  count_t       d_rise;
  count_t       d_fall;
  logic         rect_gate;

  // Write address and data channels, taken in either order
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_awready <= 1'b0;
      aw_hold   <= 1'b0;
      aw_idx    <= 8'h00;
      aw_bad    <= 1'b0;
    end else if (i_awvalid && o_awready) begin
      o_awready <= 1'b0;
      aw_hold   <= 1'b1;
      aw_idx    <= i_awaddr[`ADDR_IDX_HI:`ADDR_IDX_LO];
      aw_bad    <= i_awaddr[`ADDR_TOP_HI:`ADDR_TOP_LO] != 2'b00;
    end else if (do_write) begin
      aw_hold   <= 1'b0;
    end else if (!aw_hold) begin
      o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wready <= 1'b0;
      w_hold   <= 1'b0;
      w_data   <= 32'h0000_0000;
      w_strb   <= 4'h0;
    end else if (i_wvalid && o_wready) begin
      o_wready <= 1'b0;
      w_hold   <= 1'b1;
      w_data   <= i_wdata;
      w_strb   <= i_wstrb;
    end else if (do_write) begin
      w_hold   <= 1'b0;
    end else if (!w_hold) begin
      o_wready <= 1'b1;
    end
  end

  assign do_write = aw_hold && w_hold && !o_bvalid;

  always_comb begin
    if (aw_bad) begin
      wr_ok = 1'b0;
    end else if (aw_idx == `IDX_DRIVE_THREE_FALL || aw_idx == `IDX_DRIVE_FOUR_RISE) begin
      wr_ok = 1'b1;
    end else if (aw_idx == `IDX_DRIVE_FOUR_FALL || aw_idx == `IDX_RECT_ONE_RISE) begin
      wr_ok = 1'b1;
    end else if (aw_idx == `IDX_CONTROL || aw_idx == `IDX_PERIOD) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = aw_idx == `IDX_STATUS;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= `RESP_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      o_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Register writes; full 8-bit code fields in byte lane 0
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      codes       <= {4{`CODE_RESET}};
      resonant_en <= `CTRL_RESET;
      period      <= `PERIOD_RESET;
    end else if (do_write && !aw_bad) begin
      if (aw_idx == `IDX_DRIVE_THREE_FALL && w_strb[0]) begin
        codes.three_fall <= w_data[7:0];
      end else if (aw_idx == `IDX_DRIVE_FOUR_RISE && w_strb[0]) begin
        codes.four_rise <= w_data[7:0];
      end else if (aw_idx == `IDX_DRIVE_FOUR_FALL && w_strb[0]) begin
        codes.four_fall <= w_data[7:0];
      end else if (aw_idx == `IDX_RECT_ONE_RISE && w_strb[0]) begin
        codes.rect_rise <= w_data[7:0];
      end else if (aw_idx == `IDX_CONTROL && w_strb[0]) begin
        resonant_en <= w_data[`CTRL_RESONANT_BIT];
      end else if (aw_idx == `IDX_PERIOD) begin
        if (w_strb[0]) begin
          period[7:0] <= w_data[7:0];
        end
        if (w_strb[1]) begin
          period[15:8] <= w_data[15:8];
        end
      end
    end
  end

  // Read decode
  assign ar_idx = i_araddr[`ADDR_IDX_HI:`ADDR_IDX_LO];

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = i_araddr[`ADDR_TOP_HI:`ADDR_TOP_LO] == 2'b00;
    if (!rd_ok) begin
      rd_data = 32'h0000_0000;
    end else if (ar_idx == `IDX_DRIVE_THREE_FALL) begin
      rd_data = {24'h000000, codes.three_fall};
    end else if (ar_idx == `IDX_DRIVE_FOUR_RISE) begin
      rd_data = {24'h000000, codes.four_rise};
    end else if (ar_idx == `IDX_DRIVE_FOUR_FALL) begin
      rd_data = {24'h000000, codes.four_fall};
    end else if (ar_idx == `IDX_RECT_ONE_RISE) begin
      rd_data = {24'h000000, codes.rect_rise};
    end else if (ar_idx == `IDX_CONTROL) begin
      rd_data = {31'h0000_0000, resonant_en};
    end else if (ar_idx == `IDX_PERIOD) begin
      rd_data = {16'h0000, period};
    end else if (ar_idx == `IDX_STATUS) begin
      rd_data = {cnt, 12'h000, run, o_drive};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= `RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_data;
      o_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
    end else if (!o_rvalid) begin
      o_arready <= 1'b1;
    end
  end

  // Switching cycle counter
  assign run      = resonant_en && period_sh >= `PERIOD_MIN;
  assign boundary = !run || cnt >= period_sh - 16'h0001;

  always_ff @(posedge i_clk) begin
    if (i_rst || boundary) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end

  // Shadow copies adopted only at a cycle boundary, and on every clock while not running
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      shadow    <= {4{`CODE_RESET}};
      period_sh <= `PERIOD_RESET;
    end else if (boundary) begin
      shadow    <= codes;
      period_sh <= period;
    end
  end

  // Edge instants in cycles
  assign mid      = period_sh >> 1;
  assign lead3    = to_cycles(shadow.three_fall);
  assign lead4    = to_cycles(shadow.four_fall);
  assign rect_cyc = to_cycles(shadow.rect_rise);
  assign shift4   = shadow.four_rise[`CODE_ADVANCE_BIT] ? to_cycles(code_t'(-shadow.four_rise))
                                                       : to_cycles(shadow.four_rise);

  assign c_fall = lead3 >= period_sh ? '0 : period_sh - lead3;
  assign d_fall = lead4 >= period_sh ? '0 : period_sh - lead4;

  always_comb begin
    if (!shadow.four_rise[`CODE_ADVANCE_BIT]) begin
      d_rise = mid + shift4;
    end else if (shift4 > mid) begin
      d_rise = '0;
    end else begin
      d_rise = mid - shift4;
    end
  end

  rect_edge_delay u_rect (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_ac_sense (i_ac_sense_input),
    .i_enable   (run),
    .i_delay    (rect_cyc),
    .o_gate     (rect_gate)
  );

  // Registered outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_drive <= '0;
    end else begin
      o_drive.three <= run && cnt < c_fall;
      o_drive.four  <= run && cnt >= d_rise && cnt < d_fall;
      o_drive.rect  <= run && rect_gate;
    end
  end

  a_three_fall: assert property (@(posedge i_clk) disable iff (i_rst)
    run && cnt == c_fall |=> !o_drive.three)
    else $error("drive three high at its fall instant");

  a_four_rise: assert property (@(posedge i_clk) disable iff (i_rst)
    run && cnt == d_rise && d_rise < d_fall |=> o_drive.four)
    else $error("drive four not high at its rise instant");

  a_four_fall: assert property (@(posedge i_clk) disable iff (i_rst)
    run && cnt == d_fall |=> !o_drive.four)
    else $error("drive four high at its fall instant");

  a_step_scale: assert property (@(posedge i_clk) disable iff (i_rst)
    shadow.three_fall == 8'hFF |-> lead3 == 16'h007F)
    else $error("code step not 5 ns at 100 MHz");

  a_idle_low: assert property (@(posedge i_clk) disable iff (i_rst)
    !run ##1 !run |-> o_drive == '0)
    else $error("outputs active outside resonant mode");

  a_shadow_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !boundary |=> shadow == $past(shadow))
    else $error("code adopted inside a switching cycle");
endmodule // resonant_dead_time_edges

`default_nettype wire

// *** testbench/power_stage_model.sv ***
// Power stage model: makes the ac-sense square wave fed back by the stage.
// Assumes the bench clock; the wave runs only while enabled.
`timescale 1ns/1ps
`default_nettype none
module power_stage_model #(
  parameter int HALF = 200
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_run,
  output logic      o_ac = 1'b0
);
  int count = 0;

  // Half-period toggle
  always @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      count <= 0;
      o_ac  <= 1'b0;
    end else if (count == HALF - 1) begin
      count <= 0;
      o_ac  <= ~o_ac;
    end else begin
      count <= count + 1;
    end
  end
endmodule // power_stage_model
`default_nettype wire

// *** testbench/resonant_dead_time_edges_test.sv ***
// Self-checking bench for the resonant dead-time edge block.
// Assumes the package, the design and the power stage model compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "rdt_cfg.svh"
module resonant_dead_time_edges_test;
  import rdt_pkg::*;
  localparam int P = 300;
  // Sync, detect, arm, gate and output flops from ac-sense rise
  localparam int LAT0 = 5;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, ac_run = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, ac;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, data;
  drive_s      drv;
  logic [31:0] seed = 32'h00012314;
  logic [7:0]  ix [4] = '{`IDX_DRIVE_THREE_FALL, `IDX_DRIVE_FOUR_RISE,
                          `IDX_DRIVE_FOUR_FALL, `IDX_RECT_ONE_RISE};
  int          errors = 0;
  int          num_checks = 0;

  always #5 i_clk = ~i_clk;

  resonant_dead_time_edges DUT (
    .i_clk(i_clk), .i_rst(i_rst),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_ac_sense_input(ac), .o_drive(drv)
  );

  power_stage_model #(.HALF(200)) stage (
    .i_clk(i_clk), .i_rst(i_rst), .i_run(ac_run), .o_ac(ac)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Cycles high per switching cycle
  function automatic int exp3(input int c);
    return (c / 2 < P) ? P - c / 2 : 0;
  endfunction

  function automatic int exp4(input int cr, input int cf);
    int dr;
    int hi;
    dr = (cr < 128) ? P / 2 + cr / 2 : P / 2 - (256 - cr) / 2;
    hi = P - cf / 2;
    return (hi > dr) ? hi - dr : 0;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, b;
    b = 1'b0;
    @(posedge i_clk);
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!b) begin
      @(negedge i_clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      b  = bvalid;
      r  = bresp;
      @(posedge i_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic ta, v;
    v = 1'b0;
    @(posedge i_clk);
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!v) begin
      @(negedge i_clk);
      ta = arvalid & arready;
      v  = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge i_clk);
      if (ta) arvalid <= 1'b0;
      if (v) rready <= 1'b0;
    end
  endtask

  task automatic hold(output int n3, output int n4, output int nr);
    n3 = 0;
    n4 = 0;
    nr = 0;
    repeat (P) begin
      @(negedge i_clk);
      n3 += int'(drv.three);
      n4 += int'(drv.four);
      nr += int'(drv.rect);
    end
  endtask

  // Cycles from ac-sense rise to rectifier rise
  task automatic lat(output int n);
    n = 0;
    while (ac) @(negedge i_clk);
    while (!ac) @(negedge i_clk);
    while (!drv.rect && n < 1000) begin
      @(negedge i_clk);
      n++;
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    int n3, n4, nr, n;
    logic [7:0] c [4];
    repeat (16) @(posedge i_clk);
    i_rst  <= 1'b0;
    ac_run <= 1'b1;
    repeat (2) @(posedge i_clk);
    foreach (ix[i]) begin
      rd(ix[i], data, resp);
      chk(data, 32'h00000000);
    end
    rd(8'h4C, data, resp);
    chk(resp, `RESP_SLVERR);
    wr(8'h4C, 32'h000000FF, resp);
    chk(resp, `RESP_SLVERR);
    wstrb <= 4'h0;
    wr(ix[0], 32'h000000AA, resp);
    wstrb <= 4'hF;
    rd(ix[0], data, resp);
    chk(data, 32'h00000000);
    wr(`IDX_PERIOD, 32'(P), resp);
    chk(resp, `RESP_OKAY);
    wr(`IDX_CONTROL, 32'h00000001, resp);
    for (int t = 0; t < 6; t++) begin
      foreach (c[i]) c[i] = 8'(rnd());
      if (t == 0) c = '{8'hFF, 8'h80, 8'h00, 8'h00};
      if (t == 1) c = '{8'h00, 8'h7F, 8'hFF, 8'hFF};
      foreach (c[i]) wr(ix[i], {24'h000000, c[i]}, resp);
      foreach (c[i]) begin
        rd(ix[i], data, resp);
        chk(data, {24'h000000, c[i]});
      end
      repeat (2 * P) @(posedge i_clk);
      hold(n3, n4, nr);
      chk(n3, exp3(c[0]));
      chk(n4, exp4(c[1], c[2]));
      lat(n);
      chk(n, LAT0 + c[3] / 2);
    end
    wr(`IDX_CONTROL, 32'h00000000, resp);
    repeat (4) @(posedge i_clk);
    hold(n3, n4, nr);
    chk(n3 + n4 + nr, 0);
    rd(`IDX_STATUS, data, resp);
    chk(data, 32'h00000000);
    results();
  end

  initial begin
    repeat (60000) @(posedge i_clk);
    errors++;
    results();
  end
endmodule // resonant_dead_time_edges_test
`default_nettype wire
